/* File: verilog/sre_pkg.sv */
`default_nettype none
package sre_pkg;
	// Register widths and values after power-on
	localparam int          BYTE_W        = 8;
	localparam logic [7:0]  SRE_RESET     = 8'h00;
	localparam logic [7:0]  STB_RESET     = 8'h00;
	// Bits of the status byte that exist; bit 6 is rebuilt, never stored
	localparam logic [7:0]  STB_USED_MASK = 8'hb8;
	localparam int          SUMMARY_BIT   = 6;
	// Error queue geometry
	localparam int          ERR_W         = 16;
	localparam int          EQ_DEPTH      = 30;
	localparam logic [4:0]  EQ_PLAIN_MAX  = 5'h1d;
	localparam logic [4:0]  EQ_FULL       = 5'h1e;
	localparam logic [4:0]  EQ_LAST_IDX   = 5'h1d;
	// Error numbers, two's complement
	localparam logic [15:0] ERR_NONE      = 16'h0000;
	localparam logic [15:0] ERR_SELFTEST  = 16'hfeb6;
	localparam logic [15:0] ERR_OVERFLOW  = 16'hfea2;
	// Class bounds (inclusive) for event-status steering
	localparam logic [15:0] CMD_HI        = 16'hff9c;
	localparam logic [15:0] CMD_LO        = 16'hff39;
	localparam logic [15:0] EXE_HI        = 16'hff38;
	localparam logic [15:0] EXE_LO        = 16'hfed5;
	localparam logic [15:0] DEV_HI        = 16'hfed4;
	localparam logic [15:0] DEV_LO        = 16'hfe71;
	localparam logic [15:0] QRY_HI        = 16'hfe70;
	localparam logic [15:0] QRY_LO        = 16'hfe0d;
	// Event status bit positions per error class
	localparam int          ESR_CMD_BIT   = 5;
	localparam int          ESR_EXE_BIT   = 4;
	localparam int          ESR_DEV_BIT   = 3;
	localparam int          ESR_QRY_BIT   = 2;
	// Saved-state store
	localparam int          STATE_W       = 16;
	localparam int          SLOTS         = 21;
	localparam logic [4:0]  SLOT_AUTO     = 5'h00;
	localparam logic [4:0]  SLOT_MIN      = 5'h01;
	localparam logic [4:0]  SLOT_MAX      = 5'h14;
	// Response text selectors
	typedef enum logic [2:0] {
		TXT_NO_ERROR = 3'b000,
		TXT_OVERFLOW = 3'b001,
		TXT_SELFTEST = 3'b010,
		TXT_COMMAND  = 3'b011,
		TXT_EXECUTE  = 3'b100,
		TXT_DEVICE   = 3'b101,
		TXT_QUERY    = 3'b110,
		TXT_OTHER    = 3'b111
	} sre_text_t;
endpackage : sre_pkg
`default_nettype wire

/* File: verilog/sre_status.sv */
`timescale 1ns/1ps
`default_nettype none
module sre_status (
	input  wire logic        clk,             // 250 MHz system clock
	input  wire logic        resetn,          // Power-on reset, active low
	input  wire logic        mask_wr,         // Enable mask write strobe
	input  wire logic [7:0]  mask_wdata,      // Enable mask write value
	output logic      [7:0]  mask_rdata,      // Enable mask readback
	input  wire logic [7:0]  status_events,   // Summary inputs of other groups
	output logic      [7:0]  stb_rdata,       // Status byte query answer
	input  wire logic        serial_poll,     // Serial poll in progress
	input  wire logic        rqs_msg,         // Request message from link
	output logic      [7:0]  poll_byte,       // Serial poll answer
	output logic             srq_out,         // Service request level
	input  wire logic        ddt_wr,          // Define trigger action write
	input  wire logic [3:0]  ddt_wdata,       // Trigger action code
	input  wire logic        trg_cmd,         // Software trigger command
	input  wire logic        get_msg,         // Group execute trigger message
	output logic             trig_fire,       // Trigger action pulse
	output logic      [3:0]  trig_action,     // Action to run on trigger
	input  wire logic        tst_query,       // Self-test query strobe
	output logic             tst_start,       // Start internal tests pulse
	input  wire logic        tst_done,        // Internal tests finished
	input  wire logic [7:0]  tst_code,        // Test result, zero is pass
	output logic             tst_valid,       // Self-test answer pulse
	output logic      [7:0]  tst_resp,        // Self-test answer
	input  wire logic        wai_cmd,         // Wait-to-continue command
	input  wire logic        measuring,       // Measurement cycle busy
	input  wire logic        dev_clear,       // Device clear message
	output logic             cmd_stall,       // Hold later commands
	input  wire logic        sav_cmd,         // Save state command
	input  wire logic        rcl_cmd,         // Recall state command
	input  wire logic [4:0]  slot_sel,        // Slot number
	input  wire logic [15:0] state_in,        // Current saveable state
	output logic             state_load,      // Recalled state valid pulse
	output logic      [15:0] state_out,       // Recalled state
	input  wire logic        err_push,        // New error strobe
	input  wire logic [15:0] err_num,         // New error number
	input  wire logic        err_read,        // Error read query strobe
	input  wire logic        cls_cmd,         // Clear-status command
	output logic             err_valid,       // Error answer pulse
	output logic      [15:0] err_resp_num,    // Error answer number
	output logic      [2:0]  err_resp_text,   // Error answer text selector
	output logic      [7:0]  esr_set,         // Class bit pulses to event status
	output logic      [4:0]  err_count        // Entries held
);
	logic        rst_s1_q, rst_n_q;          // Reset release chain
	logic [7:0]  mask_q;                     // Enable mask
	logic [7:0]  stb_q;                      // Stored status bits
	logic        master_summary_flag;                        // Master summary flag
	logic [3:0]  ddt_q;                      // Configured trigger action
	logic        tst_busy_q;                 // Self-test running
	logic        pend_330_q;                 // Self-test error awaiting queue
	logic        meas_q;                     // Measuring, last cycle
	logic [15:0] slot_mem [sre_pkg::SLOTS];  // Non-volatile state image
	logic [15:0] eq_mem [sre_pkg::EQ_DEPTH]; // Error codes only, no text
	logic [4:0]  head_q;                     // Oldest entry index
	logic [4:0]  cnt_q;                      // Entries held
	logic        push;                       // Enqueue this cycle
	logic [15:0] push_num;                   // Code to enqueue
	logic        pop;                        // Dequeue this cycle
	logic [4:0]  tail;                       // Next free index
	logic [5:0]  tail_sum;                   // Unwrapped tail

	// Reset released through two flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// Enable mask; only power-on resets it, no command path clears it
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mask_q <= sre_pkg::SRE_RESET;
		end else if (mask_wr) begin
			mask_q <= mask_wdata & sre_pkg::STB_USED_MASK;
		end
	end
	assign mask_rdata = mask_q;

	// Status byte samples summaries; bit 6 never stored
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			stb_q <= sre_pkg::STB_RESET;
		end else begin
			stb_q <= status_events & sre_pkg::STB_USED_MASK;
		end
	end

	// Query is a pure read path, so nothing here changes on it
	assign master_summary_flag       = |(stb_q & mask_q);
	assign stb_rdata = stb_q | {1'b0, master_summary_flag, 6'h00};
	assign poll_byte = stb_q | {1'b0, rqs_msg & serial_poll, 6'h00};
	assign srq_out   = master_summary_flag;

	// Trigger action register and firing
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ddt_q       <= 4'h0;
			trig_fire   <= 1'b0;
			trig_action <= 4'h0;
		end else begin
			if (ddt_wr) begin
				ddt_q <= ddt_wdata;
			end
			trig_fire   <= trg_cmd | get_msg;
			trig_action <= ddt_q;
		end
	end

	// Self-test sequencing; failure queues an error later if needed
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tst_busy_q <= 1'b0;
			tst_start  <= 1'b0;
			tst_valid  <= 1'b0;
			tst_resp   <= 8'h00;
			pend_330_q <= 1'b0;
		end else begin
			tst_start <= tst_query & ~tst_busy_q;
			tst_valid <= tst_busy_q & tst_done;
			if (tst_query & ~tst_busy_q) begin
				tst_busy_q <= 1'b1;
			end else if (tst_done) begin
				tst_busy_q <= 1'b0;
			end
			if (tst_busy_q & tst_done) begin
				tst_resp <= tst_code;
			end
			// Set wins over the drain into the queue
			if (tst_busy_q & tst_done & (tst_code != 8'h00)) begin
				pend_330_q <= 1'b1;
			end else if (!err_push) begin
				pend_330_q <= 1'b0;
			end
		end
	end

	// Wait holdoff; power-on reset clears it, clear-status deliberately has no say
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cmd_stall <= 1'b0;
			meas_q    <= 1'b0;
		end else begin
			meas_q <= measuring;
			if (dev_clear) begin
				cmd_stall <= 1'b0;
			end else if (wai_cmd) begin
				cmd_stall <= 1'b1;
			end else if (meas_q & ~measuring) begin
				cmd_stall <= 1'b0;
			end
		end
	end

	// Slot store; only the saveable state word enters it
	always_ff @(posedge clk) begin
		if (rst_n_q && sav_cmd && slot_sel >= sre_pkg::SLOT_MIN && slot_sel <= sre_pkg::SLOT_MAX) begin
			slot_mem[slot_sel] <= state_in;
		end else if (rst_n_q && rcl_cmd && slot_sel <= sre_pkg::SLOT_MAX) begin
			slot_mem[sre_pkg::SLOT_AUTO] <= state_in;
		end
	end

	// Recall reads the old image before slot 0 is overwritten
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_load <= 1'b0;
			state_out  <= 16'h0000;
		end else begin
			state_load <= rcl_cmd & ~sav_cmd & (slot_sel <= sre_pkg::SLOT_MAX);
			if (rcl_cmd && slot_sel <= sre_pkg::SLOT_MAX) begin
				state_out <= slot_mem[slot_sel];
			end
		end
	end

	// One enqueue per cycle; external errors first, self-test waits
	assign push     = err_push | pend_330_q;
	assign push_num = err_push ? err_num : sre_pkg::ERR_SELFTEST;
	assign pop      = err_read & (cnt_q != 5'h00);
	assign tail_sum = {1'b0, head_q} + {1'b0, cnt_q};
	assign tail     = (tail_sum >= 6'(sre_pkg::EQ_DEPTH)) ?
		5'(tail_sum - 6'(sre_pkg::EQ_DEPTH)) : tail_sum[4:0];

	// Queue storage; last free place takes the overflow marker unless a read frees a place in the same cycle
	always_ff @(posedge clk) begin
		if (rst_n_q && push && !cls_cmd) begin
			if (cnt_q < sre_pkg::EQ_PLAIN_MAX) begin
				eq_mem[tail] <= push_num;
			end else if (cnt_q == sre_pkg::EQ_PLAIN_MAX && !pop) begin
				eq_mem[tail] <= sre_pkg::ERR_OVERFLOW;
			end else if (cnt_q == sre_pkg::EQ_PLAIN_MAX) begin
				eq_mem[tail] <= push_num;
			end
		end
	end

	// Queue pointers and count
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			head_q <= 5'h00;
			cnt_q  <= 5'h00;
		end else if (cls_cmd) begin
			head_q <= 5'h00;
			cnt_q  <= 5'h00;
		end else begin
			if (pop) begin
				head_q <= (head_q == sre_pkg::EQ_LAST_IDX) ? 5'h00 : 5'(head_q + 5'h01);
			end
			if (push && cnt_q < sre_pkg::EQ_FULL && !pop) begin
				cnt_q <= 5'(cnt_q + 5'h01);
			end else if (pop && !(push && cnt_q <= sre_pkg::EQ_PLAIN_MAX)) begin
				cnt_q <= 5'(cnt_q - 5'h01);
			end
		end
	end
	assign err_count = cnt_q;

	// Text selector from the stored code
	function automatic sre_pkg::sre_text_t text_of(input logic [15:0] n);
		sre_pkg::sre_text_t t;
		t = sre_pkg::TXT_OTHER;
		if (n == sre_pkg::ERR_NONE) begin
			t = sre_pkg::TXT_NO_ERROR;
		end else if (n == sre_pkg::ERR_OVERFLOW) begin
			t = sre_pkg::TXT_OVERFLOW;
		end else if (n == sre_pkg::ERR_SELFTEST) begin
			t = sre_pkg::TXT_SELFTEST;
		end else if (n <= sre_pkg::CMD_HI && n >= sre_pkg::CMD_LO) begin
			t = sre_pkg::TXT_COMMAND;
		end else if (n <= sre_pkg::EXE_HI && n >= sre_pkg::EXE_LO) begin
			t = sre_pkg::TXT_EXECUTE;
		end else if (n <= sre_pkg::DEV_HI && n >= sre_pkg::DEV_LO) begin
			t = sre_pkg::TXT_DEVICE;
		end else if (n <= sre_pkg::QRY_HI && n >= sre_pkg::QRY_LO) begin
			t = sre_pkg::TXT_QUERY;
		end
		return t;
	endfunction : text_of

	// Error read answer; empty queue answers with the zero code
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			err_valid     <= 1'b0;
			err_resp_num  <= sre_pkg::ERR_NONE;
			err_resp_text <= sre_pkg::TXT_NO_ERROR;
		end else begin
			err_valid <= err_read;
			if (err_read) begin
				err_resp_num  <= pop ? eq_mem[head_q] : sre_pkg::ERR_NONE;
				err_resp_text <= pop ? text_of(eq_mem[head_q]) : sre_pkg::TXT_NO_ERROR;
			end
		end
	end

	// Class bit per accepted error; positives count as device faults
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			esr_set <= 8'h00;
		end else begin
			esr_set <= 8'h00;
			if (push && !cls_cmd) begin
				if (!push_num[15] && push_num != sre_pkg::ERR_NONE) begin
					esr_set[sre_pkg::ESR_DEV_BIT] <= 1'b1;
				end else if (push_num <= sre_pkg::CMD_HI && push_num >= sre_pkg::CMD_LO) begin
					esr_set[sre_pkg::ESR_CMD_BIT] <= 1'b1;
				end else if (push_num <= sre_pkg::EXE_HI && push_num >= sre_pkg::EXE_LO) begin
					esr_set[sre_pkg::ESR_EXE_BIT] <= 1'b1;
				end else if (push_num <= sre_pkg::DEV_HI && push_num >= sre_pkg::DEV_LO) begin
					esr_set[sre_pkg::ESR_DEV_BIT] <= 1'b1;
				end else if (push_num <= sre_pkg::QRY_HI && push_num >= sre_pkg::QRY_LO) begin
					esr_set[sre_pkg::ESR_QRY_BIT] <= 1'b1;
				end
			end
		end
	end

	// Checks
	mask_bits_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		mask_wr |=> (mask_rdata == ($past(mask_wdata) & 8'hb8)))
		else $error("mask write kept dropped bits");
	mask_zero_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		mask_rdata[6] == 1'b0 && mask_rdata[2:0] == 3'h0)
		else $error("mask readback shows dropped bits");
	summary_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		stb_rdata[6] == |(stb_rdata[7:0] & mask_rdata & 8'hbf))
		else $error("summary flag wrong");
	poll_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		serial_poll |-> poll_byte[6] == rqs_msg)
		else $error("poll bit 6 not request message");
	trig_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		(trg_cmd || get_msg) |=> trig_fire)
		else $error("trigger not fired");
	stall_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		(wai_cmd && !dev_clear) |=> cmd_stall)
		else $error("wait did not stall");
	unstall_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		(cmd_stall && !wai_cmd && !dev_clear && meas_q && !measuring) |=> !cmd_stall)
		else $error("stall not released");
	empty_read_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		(err_read && err_count == 5'h00) |=> (err_valid && err_resp_num == 16'h0000))
		else $error("empty read not zero");
	depth_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		err_count <= 5'h1e)
		else $error("queue beyond thirty");
	overflow_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		(push && !pop && !cls_cmd && err_count == 5'h1d) |=>
		(err_count == 5'h1e && eq_mem[tail_sum >= 6'h1f ? 5'(tail_sum - 6'h1f) : 5'(tail_sum - 6'h01)] == 16'hfea2))
		else $error("overflow marker missing");
	cls_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		cls_cmd |=> err_count == 5'h00)
		else $error("clear-status left entries");
	selftest_a: assert property (@(posedge clk) disable iff (!rst_n_q)
		(tst_busy_q && tst_done && tst_code != 8'h00) |=> ##[0:8] (push && push_num == 16'hfeb6))
		else $error("self-test error not queued");
	fill_c: cover property (@(posedge clk) disable iff (!rst_n_q) err_count == 5'h1e);
	srq_c: cover property (@(posedge clk) disable iff (!rst_n_q) srq_out);
	wai_c: cover property (@(posedge clk) disable iff (!rst_n_q) cmd_stall ##1 !cmd_stall);
	rcl_c: cover property (@(posedge clk) disable iff (!rst_n_q) state_load);
endmodule : sre_status
`default_nettype wire

/* File: tb/sre_test_engine.sv */
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the internal test engine behind the self-test query
module sre_test_engine (
	input  wire logic       clk,       // System clock
	input  wire logic       tst_start, // Start pulse from the block
	input  wire logic [7:0] delay,     // Cycles a test pass takes
	input  wire logic [7:0] code,      // Result to hand back
	output logic            tst_done,  // Finished pulse
	output logic      [7:0] tst_code   // Result, valid with done only
);
	// Idle at time zero, then one pass per start pulse; one process drives both results
	initial begin
		tst_done = 1'b0;
		tst_code = 8'h00;
		forever begin
			@(posedge clk);
			if (tst_start === 1'b1) begin
				repeat (delay) @(posedge clk);
				@(negedge clk);
				tst_done = 1'b1;
				tst_code = code;
				@(negedge clk);
				tst_done = 1'b0;
				// Result is not held, so show a changed value
				tst_code = ~code;
			end
		end
	end
endmodule : sre_test_engine
`default_nettype wire

/* File: tb/test_status_srq_and_error_queue.sv */
`timescale 1ns/1ps
`default_nettype none
module test_status_srq_and_error_queue;
	logic        clk = 1'b0;                      // 250 MHz clock
	logic        resetn = 1'b0;                   // Power-on reset
	logic        mask_wr, serial_poll, rqs_msg;   // Mask and poll controls
	logic        ddt_wr, trg_cmd, get_msg;        // Trigger controls
	logic        tst_query, wai_cmd, measuring;   // Self-test and wait
	logic        dev_clear, sav_cmd, rcl_cmd;     // Clear and state store
	logic        err_push, err_read, cls_cmd;     // Error queue controls
	logic [7:0]  mask_wdata, status_events, mexp; // Mask data, events
	logic [3:0]  ddt_wdata;                       // Trigger action code
	logic [4:0]  slot_sel;                        // State slot
	logic [15:0] state_in, err_num;               // State word, error number
	logic [7:0]  eng_dly, eng_code;               // Engine behaviour
	wire logic        tst_done, tst_start, tst_valid;  // Self-test handshake
	wire logic [7:0]  tst_code, tst_resp;              // Self-test results
	wire logic [7:0]  mask_rdata, stb_rdata, poll_byte, esr_set; // Status outputs
	wire logic        srq_out, trig_fire, cmd_stall;   // Levels and pulses
	wire logic        state_load, err_valid;           // Answer pulses
	wire logic [3:0]  trig_action;                     // Action on trigger
	wire logic [15:0] state_out, err_resp_num;         // Answer words
	wire logic [2:0]  err_resp_text;                   // Text selector
	wire logic [4:0]  eq_count;                        // Entries held
	int          err_count = 0;                   // Mismatches
	int          cmp_count = 0;                   // Comparisons
	int          cyc = 0;                         // Cycles run
	int          i;                               // Loop index
	int          w;                               // Wait counter
	logic [15:0] sv[0:20];                        // Model of the slots
	logic [15:0] mq[$];                           // Model of the queue
	sre_status uut (.clk, .resetn, .mask_wr, .mask_wdata, .mask_rdata, .status_events,
		.stb_rdata, .serial_poll, .rqs_msg, .poll_byte, .srq_out, .ddt_wr, .ddt_wdata,
		.trg_cmd, .get_msg, .trig_fire, .trig_action, .tst_query, .tst_start, .tst_done,
		.tst_code, .tst_valid, .tst_resp, .wai_cmd, .measuring, .dev_clear, .cmd_stall,
		.sav_cmd, .rcl_cmd, .slot_sel, .state_in, .state_load, .state_out, .err_push,
		.err_num, .err_read, .cls_cmd, .err_valid, .err_resp_num, .err_resp_text,
		.esr_set, .err_count(eq_count));
	sre_test_engine eng (.clk, .tst_start, .delay(eng_dly), .code(eng_code), .tst_done,
		.tst_code);
	// Clock
	always #2 clk = ~clk;
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One-cycle strobe; outputs of the taking edge are checked on return
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse
	// Event status bit per error class, from the signed number
	function automatic logic [7:0] esr_exp(input logic [15:0] n);
		int v;
		v = int'($signed(n));
		if (v <= -100 && v >= -199) return 8'h20;
		if (v <= -200 && v >= -299) return 8'h10;
		if (v > 0 || (v <= -300 && v >= -399)) return 8'h08;
		if (v <= -400 && v >= -499) return 8'h04;
		return 8'h00;
	endfunction : esr_exp
	function automatic sre_pkg::sre_text_t txt_exp(input logic [15:0] n);
		if (n == 16'h0000) return sre_pkg::TXT_NO_ERROR;
		if (n == 16'hfea2) return sre_pkg::TXT_OVERFLOW;
		if (n == 16'hfeb6) return sre_pkg::TXT_SELFTEST;
		// Positive numbers have no class text of their own
		if (!n[15]) return sre_pkg::TXT_OTHER;
		case (esr_exp(n))
			8'h20: return sre_pkg::TXT_COMMAND;
			8'h10: return sre_pkg::TXT_EXECUTE;
			8'h08: return sre_pkg::TXT_DEVICE;
			8'h04: return sre_pkg::TXT_QUERY;
			default: return sre_pkg::TXT_OTHER;
		endcase
	endfunction : txt_exp
	// Random error of any class, positive ones included
	function automatic logic [15:0] rnd_err;
		int k;
		k = int'($urandom % 5);
		if (k == 4) return 16'(1 + $urandom % 32767);
		return 16'(-100 * (k + 1) - int'($urandom % 100));
	endfunction : rnd_err
	task automatic push(input logic [15:0] n);
		int sz;
		sz = mq.size();
		err_num = n;
		pulse(err_push);
		err_num = ~n;
		if (sz < 29) mq.push_back(n);
		else if (sz == 29) mq.push_back(16'hfea2);
		chk("count", 16'(mq.size()), {11'h000, eq_count});
		if (sz < 29) chk("esr_set", {8'h00, esr_exp(n)}, {8'h00, esr_set});
	endtask : push
	task automatic rd;
		logic [15:0] n;
		pulse(err_read);
		n = (mq.size() == 0) ? 16'h0000 : mq.pop_front();
		chk("err_valid", 16'h0001, {15'h0000, err_valid});
		chk("err_num", n, err_resp_num);
		chk("err_text", {13'h0000, txt_exp(n)}, {13'h0000, err_resp_text});
		chk("count", 16'(mq.size()), {11'h000, eq_count});
	endtask : rd
	// Save or recall with a fresh state word on the input
	task automatic sr(input logic rcl, input logic [4:0] s);
		logic [15:0] v;
		v = 16'($urandom);
		slot_sel = s;
		state_in = v;
		if (rcl) begin
			pulse(rcl_cmd);
			chk("load", 16'h0001, {15'h0000, state_load});
			chk("state", sv[s], state_out);
			sv[0] = v;
		end else begin
			pulse(sav_cmd);
			if (s >= 1 && s <= 20) sv[s] = v;
		end
	endtask : sr
	initial begin
		{mask_wr, serial_poll, rqs_msg, ddt_wr, trg_cmd, get_msg, tst_query} = '0;
		{wai_cmd, measuring, dev_clear, sav_cmd, rcl_cmd, err_push, err_read, cls_cmd} = '0;
		{mask_wdata, status_events, ddt_wdata, slot_sel, state_in, err_num} = '0;
		eng_dly = 8'h02;
		eng_code = 8'h00;
		void'($urandom(32'h4ef7));
		repeat (12) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		chk("mask", 16'h0000, {8'h00, mask_rdata});
		chk("stb", 16'h0000, {8'h00, stb_rdata});
		chk("count", 16'h0000, {11'h000, eq_count});
		rd();
		// Mask write, status byte, summary flag and serial poll
		for (i = 0; i < 8; i++) begin
			mask_wdata = 8'($urandom);
			mexp = mask_wdata & 8'hb8;
			pulse(mask_wr);
			chk("mask", {8'h00, mexp}, {8'h00, mask_rdata});
			status_events = 8'($urandom);
			rqs_msg = i[0];
			serial_poll = i[1];
			repeat (2) @(negedge clk);
			chk("stb", {8'h00, status_events & 8'hb8 | {1'b0, |(status_events & mexp), 6'h00}},
				{8'h00, stb_rdata});
			chk("srq", {15'h0000, |(status_events & mexp)}, {15'h0000, srq_out});
			chk("poll", {8'h00, status_events & 8'hb8 | {1'b0, i[0] & i[1], 6'h00}},
				{8'h00, poll_byte});
			@(negedge clk);
			chk("stb_again", {8'h00, status_events & 8'hb8 | {1'b0, |(status_events & mexp), 6'h00}},
				{8'h00, stb_rdata});
		end
		// Both trigger sources run the defined action
		for (i = 0; i < 4; i++) begin
			ddt_wdata = 4'($urandom);
			pulse(ddt_wr);
			if (i[0]) pulse(get_msg);
			else pulse(trg_cmd);
			chk("fire", 16'h0001, {15'h0000, trig_fire});
			chk("action", {12'h000, ddt_wdata}, {12'h000, trig_action});
		end
		// Save and recall, slot 0 refilled by each recall
		sr(1'b0, 5'h01);
		sr(1'b0, 5'h14);
		sr(1'b0, 5'h00);
		sr(1'b1, 5'h14);
		sr(1'b1, 5'h01);
		sr(1'b1, 5'h00);
		sr(1'b0, 5'h00);
		sr(1'b1, 5'h00);
		chk("mask_kept", {8'h00, mexp}, {8'h00, mask_rdata});
		// Wait survives clear-status, ends on measuring falling or device clear
		measuring = 1'b1;
		pulse(wai_cmd);
		chk("stall", 16'h0001, {15'h0000, cmd_stall});
		pulse(cls_cmd);
		mq.delete();
		chk("stall_cls", 16'h0001, {15'h0000, cmd_stall});
		measuring = 1'b0;
		repeat (2) @(negedge clk);
		chk("stall_end", 16'h0000, {15'h0000, cmd_stall});
		measuring = 1'b1;
		pulse(wai_cmd);
		pulse(dev_clear);
		@(negedge clk);
		chk("stall_dcl", 16'h0000, {15'h0000, cmd_stall});
		measuring = 1'b0;
		// Self-test: a quick pass, then a slow failing run
		for (i = 0; i < 2; i++) begin
			eng_code = i[0] ? 8'h05 : 8'h00;
			eng_dly = i[0] ? 8'h09 : 8'h02;
			pulse(tst_query);
			w = 0;
			while (tst_valid !== 1'b1 && w < 60) begin
				@(negedge clk);
				w++;
			end
			chk("tst_valid", 16'h0001, {15'h0000, tst_valid});
			chk("tst_resp", {8'h00, eng_code}, {8'h00, tst_resp});
			if (i[0]) mq.push_back(16'hfeb6);
			repeat (3) @(negedge clk);
			chk("count", 16'(mq.size()), {11'h000, eq_count});
		end
		// Fill past overflow, free a slot, drain past empty, then clear
		for (i = 0; i < 32; i++) push(rnd_err());
		rd();
		push(rnd_err());
		for (i = 0; i < 32; i++) rd();
		push(rnd_err());
		push(rnd_err());
		pulse(cls_cmd);
		mq.delete();
		@(negedge clk);
		chk("count_cls", 16'h0000, {11'h000, eq_count});
		rd();
		give_verdict();
	end
endmodule : test_status_srq_and_error_queue
`default_nettype wire
